// file: rtl/mcp_pkg.sv
package mcp_pkg;

   // ==========================================================
   // Sizes.
   localparam int NUM_BANKS = 8;
   localparam int NUM_LANES = 8;
   localparam int NUM_LINES = 6;
   localparam int ADDR_W = 32;
   localparam int WORD_W = 16;

   // ==========================================================
   // Machine selectors per bank.
   localparam logic [1:0] MACH_SIMPLE = 2'h0;
   localparam logic [1:0] MACH_SDRAM = 2'h1;
   localparam logic [1:0] MACH_PROG = 2'h2;

   // Port size codes: 8, 16, 32 and 64 bit.
   localparam logic [1:0] PORT_8 = 2'h0;
   localparam logic [1:0] PORT_16 = 2'h1;
   localparam logic [1:0] PORT_32 = 2'h2;
   localparam logic [1:0] PORT_64 = 2'h3;

   // Buffer control function codes.
   localparam logic [1:0] BCF_DIR = 2'h0;
   localparam logic [1:0] BCF_ENA = 2'h1;
   localparam logic [1:0] BCF_SPLIT = 2'h2;

   // Burst and SDRAM address bit positions, programmable machine depth.
   localparam int BADDR_LO = 27;
   localparam int BADDR_HI = 28;
   localparam int SD_A10_BIT = 10;
   localparam int PROG_DEPTH = 16;
   localparam int PROG_IDX_W = 4;

   // Simple machine cycle count, from 0, at which the access terminates internally.
   localparam logic [3:0] SIMPLE_TIMEOUT = 4'hf;

   // Word layout of the programmable machine: lines, lanes enable, select enable (unused, the select holds for the whole access), wait enable, last.
   localparam int PW_LINES_LO = 0;
   localparam int PW_LANE_EN = 6;
   localparam int PW_CS_EN = 7;
   localparam int PW_WAIT_EN = 8;
   localparam int PW_LAST = 9;

   typedef enum logic [2:0] {
      MCP_IDLE = 3'b000,
      MCP_SIMPLE = 3'b001,
      MCP_SD_ROW = 3'b010,
      MCP_SD_COL = 3'b011,
      MCP_SD_END = 3'b100,
      MCP_PROG = 3'b101
   } mcp_state_e;

endpackage

// file: rtl/mcp_lane_dec.sv
`timescale 1ns/10ps
// Byte lane decoder from address offset, transfer size and port size.
module mcp_lane_dec (
   // Access description.
   input wire logic [2:0] addr_lo,
   input wire logic [3:0] xfer_bytes,
   input wire logic [1:0] port_size,
   // Lane result.
   output logic [7:0] lanes
);
   logic [3:0] port_bytes;
   logic [2:0] off;
   logic [15:0] span;

   // Port width in bytes and the offset inside that port.
   always_comb begin
      case (port_size)
         mcp_pkg::PORT_8: port_bytes = 4'h1;
         mcp_pkg::PORT_16: port_bytes = 4'h2;
         mcp_pkg::PORT_32: port_bytes = 4'h4;
         default: port_bytes = 4'h8;
      endcase
      off = addr_lo & 3'(port_bytes - 4'h1);
      span = ((16'h1 << xfer_bytes) - 16'h1) << off;
      lanes = span[7:0] & 8'((16'h1 << port_bytes) - 16'h1);
   end
endmodule

// file: rtl/mcp_ctrl.sv
`timescale 1ns/10ps
// External bus memory controller pin sequencer.
module mcp_ctrl #(
   parameter int NUM_BANKS = mcp_pkg::NUM_BANKS,
   parameter int NUM_LINES = mcp_pkg::NUM_LINES
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic nrst,
   // Configuration levels.
   input wire logic [1:0] buffer_ctrl_function_field,
   input wire logic ext_master_mode,
   input wire logic [NUM_BANKS*32-1:0] bank_base,
   input wire logic [NUM_BANKS*32-1:0] bank_mask,
   input wire logic [NUM_BANKS-1:0] bank_valid,
   input wire logic [NUM_BANKS*2-1:0] bank_machine,
   input wire logic [NUM_BANKS*2-1:0] bank_port,
   // Programmable machine storage load port.
   input wire logic prog_we,
   input wire logic [mcp_pkg::PROG_IDX_W-1:0] prog_waddr,
   input wire logic [9:0] prog_wdata,
   // Internal access request.
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [31:0] req_addr,
   input wire logic [3:0] req_bytes,
   input wire logic req_write,
   input wire logic req_parity,
   output logic done_pulse,
   // Inputs from devices.
   input wire logic chipsel_machine_ack_in,
   input wire logic prog_machine_wait_in,
   // Pins toward memories.
   output logic [NUM_BANKS-1:0] chip_sel_n,
   output logic data_buffer_ctrl_a,
   output logic data_buffer_ctrl_b,
   output logic [1:0] burst_addr_out,
   output logic addr_latch_en,
   output logic [7:0] lane_write_strobe,
   output logic [7:0] sdram_lane_mask,
   output logic [7:0] prog_lane_select,
   output logic sdram_addr_bit_ten,
   output logic [NUM_LINES-1:0] prog_line,
   output logic sdram_write_cmd,
   output logic sdram_row_strobe,
   output logic sdram_col_strobe,
   output logic mem_read_output_enable,
   output logic parity_chip_select,
   output logic sdram_addr_mux_sel
);
   // ==========================================================
   // Input synchronisers.
   logic ack_s1_ff, ack_ff, ack_q_ff, wait_s1_ff, wait_ff;
   logic ack_fell;

   // Two flops on each device input; the acknowledge has a third for its fall.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ack_s1_ff <= 1'b1;
         ack_ff <= 1'b1;
         ack_q_ff <= 1'b1;
         wait_s1_ff <= 1'b0;
         wait_ff <= 1'b0;
      end else begin
         ack_s1_ff <= chipsel_machine_ack_in;
         ack_ff <= ack_s1_ff;
         ack_q_ff <= ack_ff;
         wait_s1_ff <= prog_machine_wait_in;
         wait_ff <= wait_s1_ff;
      end
   end

   // Only a fresh fall of the acknowledge ends an access, so an answer that
   // is still draining through the synchroniser cannot end the next one.
   assign ack_fell = ack_q_ff && !ack_ff;

   // ==========================================================
   // Bank match.
   logic [NUM_BANKS-1:0] hit_oh;
   logic [2:0] hit_idx;
   logic hit_any;

   // Lowest matching bank wins so only one select can assert.
   always_comb begin
      hit_oh = '0;
      hit_idx = 3'h0;
      hit_any = 1'b0;
      for (int i = NUM_BANKS - 1; i >= 0; i--) begin
         if (bank_valid[i] && ((req_addr & bank_mask[i*32 +: 32]) ==
             (bank_base[i*32 +: 32] & bank_mask[i*32 +: 32]))) begin
            hit_idx = 3'(i);
            hit_any = 1'b1;
         end
      end
      if (hit_any) begin
         hit_oh[hit_idx] = 1'b1;
      end
   end

   // ==========================================================
   // Lane decode.
   logic [7:0] lanes;

   mcp_lane_dec u_lane (
      .addr_lo(req_addr[2:0]),
      .xfer_bytes(req_bytes),
      .port_size(bank_port[hit_idx*2 +: 2]),
      .lanes(lanes)
   );

   // ==========================================================
   // Programmable machine storage.
   logic [9:0] prog_mem_ff [mcp_pkg::PROG_DEPTH];

   // Word load from the configuration side.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         for (int i = 0; i < mcp_pkg::PROG_DEPTH; i++) begin
            prog_mem_ff[i] <= 10'h200;
         end
      end else if (prog_we) begin
         prog_mem_ff[prog_waddr] <= prog_wdata;
      end
   end

   // ==========================================================
   // Sequencer.
   mcp_pkg::mcp_state_e state_ff;
   logic [3:0] cnt_ff;
   logic [NUM_BANKS-1:0] cs_ff;
   logic [7:0] lanes_ff;
   logic wr_ff, par_ff;
   logic [31:0] addr_ff;
   logic [9:0] pword;
   logic take, stall;

   assign req_ready = (state_ff == mcp_pkg::MCP_IDLE);
   assign take = req_valid && req_ready && hit_any;
   assign pword = prog_mem_ff[cnt_ff];
   assign stall = pword[mcp_pkg::PW_WAIT_EN] && wait_ff;

   // State, counter and captured access.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_ff <= mcp_pkg::MCP_IDLE;
         cnt_ff <= 4'h0;
         cs_ff <= '0;
         lanes_ff <= 8'h00;
         wr_ff <= 1'b0;
         par_ff <= 1'b0;
         addr_ff <= 32'h0;
         done_pulse <= 1'b0;
      end else begin
         done_pulse <= 1'b0;
         case (state_ff)
            mcp_pkg::MCP_IDLE: begin
               if (take) begin
                  cs_ff <= hit_oh;
                  lanes_ff <= lanes;
                  wr_ff <= req_write;
                  par_ff <= req_parity;
                  addr_ff <= req_addr;
                  cnt_ff <= 4'h0;
                  case (bank_machine[hit_idx*2 +: 2])
                     mcp_pkg::MACH_SDRAM: state_ff <= mcp_pkg::MCP_SD_ROW;
                     mcp_pkg::MACH_PROG: state_ff <= mcp_pkg::MCP_PROG;
                     default: state_ff <= mcp_pkg::MCP_SIMPLE;
                  endcase
               end
            end
            mcp_pkg::MCP_SIMPLE: begin
               cnt_ff <= cnt_ff + 4'h1;
               if (ack_fell || cnt_ff == mcp_pkg::SIMPLE_TIMEOUT) begin
                  state_ff <= mcp_pkg::MCP_IDLE;
                  cs_ff <= '0;
                  done_pulse <= 1'b1;
               end
            end
            mcp_pkg::MCP_SD_ROW: state_ff <= mcp_pkg::MCP_SD_COL;
            mcp_pkg::MCP_SD_COL: state_ff <= mcp_pkg::MCP_SD_END;
            mcp_pkg::MCP_SD_END: begin
               state_ff <= mcp_pkg::MCP_IDLE;
               cs_ff <= '0;
               done_pulse <= 1'b1;
            end
            mcp_pkg::MCP_PROG: begin
               if (!stall) begin
                  cnt_ff <= cnt_ff + 4'h1;
                  if (pword[mcp_pkg::PW_LAST] ||
                      cnt_ff == 4'(mcp_pkg::PROG_DEPTH - 1)) begin
                     state_ff <= mcp_pkg::MCP_IDLE;
                     cs_ff <= '0;
                     done_pulse <= 1'b1;
                  end
               end
            end
            default: state_ff <= mcp_pkg::MCP_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Registered pin drive.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         chip_sel_n <= '1;
         lane_write_strobe <= 8'hff;
         sdram_lane_mask <= 8'hff;
         prog_lane_select <= 8'hff;
         mem_read_output_enable <= 1'b1;
         sdram_row_strobe <= 1'b1;
         sdram_col_strobe <= 1'b1;
         sdram_write_cmd <= 1'b1;
         sdram_addr_bit_ten <= 1'b0;
         sdram_addr_mux_sel <= 1'b0;
         prog_line <= '1;
         parity_chip_select <= 1'b1;
         burst_addr_out <= 2'h0;
         addr_latch_en <= 1'b0;
         data_buffer_ctrl_a <= 1'b1;
         data_buffer_ctrl_b <= 1'b1;
      end else begin
         chip_sel_n <= ~cs_ff;
         lane_write_strobe <= (state_ff == mcp_pkg::MCP_SIMPLE && wr_ff) ?
            ~lanes_ff : 8'hff;
         mem_read_output_enable <=
            !(state_ff == mcp_pkg::MCP_SIMPLE && !wr_ff);
         sdram_lane_mask <= (state_ff == mcp_pkg::MCP_SD_COL) ?
            ~lanes_ff : 8'hff;
         sdram_row_strobe <= !(state_ff == mcp_pkg::MCP_SD_ROW);
         sdram_col_strobe <= !(state_ff == mcp_pkg::MCP_SD_COL);
         sdram_write_cmd <= !(state_ff == mcp_pkg::MCP_SD_COL && wr_ff);
         // Row phase carries the address bit; column phase leaves it low.
         sdram_addr_bit_ten <= (state_ff == mcp_pkg::MCP_SD_ROW) ?
            addr_ff[mcp_pkg::SD_A10_BIT] : 1'b0;
         sdram_addr_mux_sel <= ext_master_mode &&
            state_ff == mcp_pkg::MCP_SD_COL;
         if (state_ff == mcp_pkg::MCP_PROG) begin
            prog_line <= pword[mcp_pkg::PW_LINES_LO +: NUM_LINES];
            prog_lane_select <= pword[mcp_pkg::PW_LANE_EN] ?
               ~lanes_ff : 8'hff;
         end else begin
            prog_line <= '1;
            prog_lane_select <= 8'hff;
         end
         parity_chip_select <= !(par_ff && |cs_ff);
         burst_addr_out <=
            addr_ff[mcp_pkg::BADDR_HI:mcp_pkg::BADDR_LO];
         addr_latch_en <= ext_master_mode && take;
         // Buffer controls: direction plus enable, enable only, or split read/write.
         case (buffer_ctrl_function_field)
            mcp_pkg::BCF_DIR: begin
               data_buffer_ctrl_a <= !wr_ff;
               data_buffer_ctrl_b <= !(|cs_ff);
            end
            mcp_pkg::BCF_SPLIT: begin
               data_buffer_ctrl_a <= !(|cs_ff && wr_ff);
               data_buffer_ctrl_b <= !(|cs_ff && !wr_ff);
            end
            default: begin
               data_buffer_ctrl_a <= !(|cs_ff);
               data_buffer_ctrl_b <= 1'b1;
            end
         endcase
      end
   end
endmodule

// file: sim/mcp_ctrl_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Pin checker for the memory controller.
module mcp_ctrl_sva #(
   parameter int NUM_BANKS = 8
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic nrst,
   // Watched ports.
   input wire logic ext_master_mode,
   input wire logic chipsel_machine_ack_in,
   input wire logic done_pulse,
   input wire logic [NUM_BANKS-1:0] chip_sel_n,
   input wire logic addr_latch_en,
   input wire logic [7:0] lane_write_strobe,
   input wire logic [7:0] sdram_lane_mask,
   input wire logic sdram_addr_bit_ten,
   input wire logic sdram_row_strobe,
   input wire logic sdram_col_strobe,
   input wire logic mem_read_output_enable,
   input wire logic sdram_addr_mux_sel
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   property p_one_cs; $onehot0(~chip_sel_n); endproperty
   a_one_cs: assert property (p_one_cs) else $error("two selects");
   property p_ale;
      !ext_master_mode && !$past(ext_master_mode) |-> !addr_latch_en;
   endproperty
   a_ale: assert property (p_ale) else $error("stray latch");
   property p_mux;
      !ext_master_mode && !$past(ext_master_mode) |-> !sdram_addr_mux_sel;
   endproperty
   a_mux: assert property (p_mux) else $error("stray mux");
   property p_oe; !mem_read_output_enable |-> !(&chip_sel_n); endproperty
   a_oe: assert property (p_oe) else $error("oe no select");
   property p_we;
      lane_write_strobe != 8'hff |-> mem_read_output_enable && !(&chip_sel_n);
   endproperty
   a_we: assert property (p_we) else $error("bad strobe");
   property p_rc;
      $fell(sdram_row_strobe) |=> !sdram_col_strobe && sdram_row_strobe;
   endproperty
   a_rc: assert property (p_rc) else $error("row col order");
   property p_a10; !sdram_col_strobe |-> !sdram_addr_bit_ten; endproperty
   a_a10: assert property (p_a10) else $error("a10 on col");
   property p_dqm; !sdram_col_strobe |-> sdram_lane_mask != 8'hff; endproperty
   a_dqm: assert property (p_dqm) else $error("no lane mask");
   property p_done; done_pulse |=> !done_pulse; endproperty
   a_done: assert property (p_done) else $error("long done");
   property p_ack; $fell(chipsel_machine_ack_in) |-> ##[1:6] done_pulse;
   endproperty
   a_ack: assert property (p_ack) else $error("ack ignored");
endmodule

// file: sim/mcp_mem_model.sv
`timescale 1ns/10ps
// ==========================================================
// Far side memory: acknowledge and wait sources.
module mcp_mem_model (
   // Clock and pins.
   input wire logic mclk,
   input wire logic [7:0] chip_sel_n,
   // Bench knobs.
   input wire logic ack_en,
   input wire logic [3:0] ack_dly,
   input wire logic wait_req,
   // Answers.
   output logic chipsel_machine_ack_in,
   output logic prog_machine_wait_in
);
   logic [3:0] cnt_ff = 4'h0;
   // Counts cycles of a held select.
   always @(posedge mclk) begin
      if (&chip_sel_n) cnt_ff <= 4'h0;
      else if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
   end
   // Ack goes low after the delay; the pull-up holds it high otherwise.
   initial chipsel_machine_ack_in = 1'b1;
   always @(posedge mclk) begin
      chipsel_machine_ack_in <= !(ack_en && !(&chip_sel_n) &&
         cnt_ff >= ack_dly);
   end
   // Wait is high only while the bench asks; pulled low otherwise.
   assign prog_machine_wait_in = wait_req;
endmodule

// file: sim/memory_controller_pin_interface_tb.sv
`timescale 1ns/10ps
// ==========================================================
// Bench for the memory controller pins.
module memory_controller_pin_interface_tb;
   logic mclk = 0, nrst = 0, ext_master_mode = 0, prog_we = 0;
   logic [1:0] buffer_ctrl_function_field = mcp_pkg::BCF_DIR;
   logic [255:0] bank_base = {160'h0, 96'h300000002000000010000000};
   logic [255:0] bank_mask = {8{32'hf0000000}};
   logic [7:0] bank_valid = 8'h07;
   logic [15:0] bank_machine = {10'h0, mcp_pkg::MACH_PROG,
      mcp_pkg::MACH_SDRAM, mcp_pkg::MACH_SIMPLE};
   logic [15:0] bank_port = {10'h0, mcp_pkg::PORT_64, mcp_pkg::PORT_64,
      mcp_pkg::PORT_32};
   logic [3:0] prog_waddr = 4'h0, req_bytes = 4'h0, ack_dly = 4'h1;
   logic [9:0] prog_wdata = 10'h0;
   logic [31:0] req_addr = 32'h0;
   logic req_valid = 0, req_write = 0, req_parity = 0, ack_en = 0;
   logic wait_req = 0, req_ready, done_pulse, chipsel_machine_ack_in;
   logic prog_machine_wait_in, data_buffer_ctrl_a, data_buffer_ctrl_b;
   logic addr_latch_en, sdram_addr_bit_ten, sdram_write_cmd;
   logic sdram_row_strobe, sdram_col_strobe, mem_read_output_enable;
   logic parity_chip_select, sdram_addr_mux_sel;
   logic [1:0] burst_addr_out, ba_s, bc_s;
   logic [5:0] prog_line, ln_s;
   logic [7:0] chip_sel_n, lane_write_strobe, sdram_lane_mask;
   logic [7:0] prog_lane_select, cs_s, we_s, msk_s, pbs_s;
   logic oe_s, par_s, ras_s, cas_s, swe_s, a10_s, ale_s, mux_s, rdy_s;
   int failures = 0, compares = 0, n, cyc = 0;
   mcp_ctrl mcp_ctrl_i (.mclk, .nrst, .buffer_ctrl_function_field,
      .ext_master_mode, .bank_base, .bank_mask, .bank_valid, .bank_machine,
      .bank_port, .prog_we, .prog_waddr, .prog_wdata, .req_valid,
      .req_ready, .req_addr, .req_bytes, .req_write, .req_parity,
      .done_pulse, .chipsel_machine_ack_in, .prog_machine_wait_in,
      .chip_sel_n, .data_buffer_ctrl_a, .data_buffer_ctrl_b,
      .burst_addr_out, .addr_latch_en, .lane_write_strobe,
      .sdram_lane_mask, .prog_lane_select, .sdram_addr_bit_ten, .prog_line,
      .sdram_write_cmd, .sdram_row_strobe, .sdram_col_strobe,
      .mem_read_output_enable, .parity_chip_select, .sdram_addr_mux_sel);
   mcp_mem_model mcp_mem_model_i (.mclk, .chip_sel_n, .ack_en, .ack_dly,
      .wait_req, .chipsel_machine_ack_in, .prog_machine_wait_in);
   // Free running clock and hang guard.
   initial forever #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         summarize();
      end
   end
   // Counts one comparison and reports a mismatch.
   task chk(input logic c, input string m);
      compares++;
      if (c !== 1'b1) begin
         failures++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   // One access, collecting what each pin did until done.
   task access(input logic [31:0] a, input logic [3:0] b, input logic w,
      input logic p, input int hold);
      {cs_s, we_s, msk_s, pbs_s, ln_s} = '1;
      {oe_s, par_s, ras_s, cas_s, swe_s, bc_s} = '1;
      {a10_s, ale_s, mux_s, ba_s} = '0;
      req_valid <= 1;
      req_addr <= a;
      req_bytes <= b;
      req_write <= w;
      req_parity <= p;
      @(posedge mclk);
      req_valid <= 0;
      // The latch pulse and the busy state stand from the edge that takes.
      @(negedge mclk);
      ale_s |= addr_latch_en;
      rdy_s = req_ready;
      for (n = 0; n < 60; n++) begin
         @(posedge mclk);
         if (n == hold) wait_req <= 0;
         @(negedge mclk);
         cs_s &= chip_sel_n;
         we_s &= lane_write_strobe;
         msk_s &= sdram_lane_mask;
         pbs_s &= prog_lane_select;
         ln_s &= prog_line;
         oe_s &= mem_read_output_enable;
         par_s &= parity_chip_select;
         ras_s &= sdram_row_strobe;
         cas_s &= sdram_col_strobe;
         swe_s &= sdram_write_cmd;
         bc_s &= {data_buffer_ctrl_a, data_buffer_ctrl_b};
         ale_s |= addr_latch_en;
         mux_s |= sdram_addr_mux_sel;
         if (!sdram_row_strobe) a10_s |= sdram_addr_bit_ten;
         if (!(&chip_sel_n)) ba_s = burst_addr_out;
         if (done_pulse === 1'b1) break;
      end
      @(posedge mclk);
   endtask
   // Simple machine write ended by acknowledge, then read by timeout.
   task t_simple;
      ack_en <= 1;
      access(32'h10000001, 4'h1, 1, 0, 99);
      chk(cs_s === 8'hfe, "cs wr");
      chk(we_s === 8'hfd, "strobe");
      chk(oe_s === 1'b1, "oe wr");
      chk(n < 12, "ack end");
      chk(rdy_s === 1'b0, "busy");
      ack_en <= 0;
      access(32'h10000000, 4'h4, 0, 0, 99);
      chk(oe_s === 1'b0 && we_s === 8'hff, "oe rd");
      chk(n > 12 && n < 40, "timeout");
      $display("simple done");
   endtask
   // SDRAM read with parity, then write under external master.
   task t_sdram;
      access(32'h28000400, 4'h8, 0, 1, 99);
      chk(cs_s === 8'hfd, "cs sd");
      chk(ras_s === 1'b0 && cas_s === 1'b0, "ras cas");
      chk(a10_s === 1'b1, "a10 row");
      chk(msk_s === 8'h00, "mask 8");
      chk(ba_s === 2'h1, "baddr");
      chk(par_s === 1'b0, "parity");
      chk(ale_s === 1'b0, "ale off");
      chk(bc_s === 2'h2, "buf dir");
      ext_master_mode <= 1;
      buffer_ctrl_function_field <= mcp_pkg::BCF_SPLIT;
      access(32'h20000000, 4'h1, 1, 0, 99);
      chk(ale_s === 1'b1, "ale on");
      chk(mux_s === 1'b1, "mux");
      chk(swe_s === 1'b0, "sd we");
      chk(msk_s === 8'hfe && ba_s === 2'h0, "mask 1");
      chk(bc_s === 2'h1, "buf split");
      ext_master_mode <= 0;
      $display("sdram done");
   endtask
   // Programmable word obeying wait, with lines and lane selects.
   task t_prog;
      prog_we <= 1;
      prog_wdata <= 10'h355;
      wait_req <= 1;
      buffer_ctrl_function_field <= mcp_pkg::BCF_ENA;
      @(posedge mclk);
      prog_we <= 0;
      // Let the raised wait pass the synchroniser before the access starts.
      @(posedge mclk);
      access(32'h30000002, 4'h2, 0, 0, 12);
      chk(bc_s === 2'h1, "buf ena");
      chk(n > 11 && n < 40, "wait");
      chk(ln_s === 6'h15, "lines");
      chk(pbs_s === 8'hf3, "lane sel");
      $display("prog done");
   endtask
   // Prints the counts and the verdict, then stops.
   task summarize;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence.
   initial begin
      repeat (16) @(posedge mclk);
      nrst <= 1;
      @(posedge mclk);
      t_simple();
      t_sdram();
      t_prog();
      summarize();
   end
endmodule
bind mcp_ctrl mcp_ctrl_sva #(.NUM_BANKS(NUM_BANKS)) mcp_ctrl_sva_i (.mclk,
   .nrst, .ext_master_mode, .chipsel_machine_ack_in, .done_pulse,
   .chip_sel_n, .addr_latch_en, .lane_write_strobe, .sdram_lane_mask,
   .sdram_addr_bit_ten, .sdram_row_strobe, .sdram_col_strobe,
   .mem_read_output_enable, .sdram_addr_mux_sel);
